//--- vml_pkg.sv
// ***************************************************************
// constants shared by the output target logic
// ***************************************************************
package vml_pkg;

  // command codes of the word registers
  localparam logic [7:0] VML_CMD_UPPER_LIMIT = 8'h24;
  localparam logic [7:0] VML_CMD_MARGIN_HIGH = 8'h25;
  localparam logic [7:0] VML_CMD_MARGIN_LOW = 8'h26;
  localparam logic [7:0] VML_CMD_SLEW_RATE = 8'h27;

  // slew word layout: exponent in 15:11, mantissa in 10:0
  localparam int VML_SLEW_EXP_MSB = 15;
  localparam int VML_SLEW_EXP_LSB = 11;
  localparam int VML_SLEW_MAN_MSB = 10;
  localparam int VML_SLEW_MAN_LSB = 0;
  localparam logic [4:0] VML_SLEW_EXP_RST = 5'h1c; // exponent -4, 0.0625 mV/us steps

  // set-point validity ceilings in mV, per loop scale factor 1.0, 0.5, 0.25, 0.125
  localparam logic [12:0] VML_VALID_MV_S1 = 13'd700;
  localparam logic [12:0] VML_VALID_MV_S2 = 13'd1400;
  localparam logic [12:0] VML_VALID_MV_S4 = 13'd2800;
  localparam logic [12:0] VML_VALID_MV_S8 = 13'd6000;
  // reference converter reach: 0.75 V divided by the scale factor
  localparam logic [12:0] VML_DAC_MV = 13'd750;

  // slew rate bounds in micro-mV/us (0.067 and 15.933 mV/us)
  localparam logic [39:0] VML_RATE_MIN_UMV = 40'd67000;
  localparam logic [39:0] VML_RATE_MAX_UMV = 40'd15933000;
  localparam int VML_RATE_FRAC_BITS = 10; // rate kept in 2^-10 mV/us, product taken 64 bits wide
  localparam int VML_EFF_SHIFT = 6; // 2^-10 to 2^-4 steps
  localparam int VML_MAX_SHIFT = 12; // finest output lsb handled: 2^-12 V

  // slew accumulator wrap: 16 steps per mV, 1000 mV per V, cycles per us
  localparam int VML_CLK_MHZ = 100;
  localparam int VML_ACC_WRAP = 16 * 1000 * VML_CLK_MHZ;

  // set-point source picked by the operation margin bits
  typedef enum logic [1:0] {
    VML_SRC_NOMINAL = 2'b00,
    VML_SRC_LOW = 2'b01,
    VML_SRC_HIGH = 2'b10
  } vml_src_t;

endpackage : vml_pkg

//--- vml_slew_engine.sv
`timescale 1ns/100ps
// ***************************************************************
// reference slew engine
// ***************************************************************
module vml_slew_engine #(
  parameter int INC_W = 20
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_conv_en,
  input wire logic [15:0] i_target,
  input wire logic [INC_W-1:0] i_inc,
  output logic [15:0] o_vref,
  output logic o_busy
);

  localparam logic [21:0] ACC_WRAP = 22'(vml_pkg::VML_ACC_WRAP);

  initial
  begin
    // a full increment must stay below the wrap, else two lsb could move at once
    if (INC_W > 20 || INC_W < 1)
      $error("increment width not served by the wrap");
  end

  logic [21:0] acc_reg; // fractional lsb progress
  logic [21:0] acc_next;
  logic [15:0] ref_reg; // present reference
  logic [15:0] ref_next;
  logic [21:0] acc_sum;

  // one lsb move per wrap; the wrap is above any single increment,
  // so at most one lsb moves per cycle and the target is never passed
  always_comb
  begin
    acc_sum = acc_reg + 22'(i_inc);
    acc_next = acc_reg;
    ref_next = ref_reg;
    if (!i_conv_en)
    begin
      // turn-on and turn-off ramps are not slewed here
      ref_next = i_target;
      acc_next = 22'h0;
    end
    else if (ref_reg == i_target)
      acc_next = 22'h0;
    else if (acc_sum >= ACC_WRAP)
    begin
      acc_next = acc_sum - ACC_WRAP;
      // step toward the target only, stop on it
      ref_next = (ref_reg < i_target) ? ref_reg + 16'h1 : ref_reg - 16'h1;
    end
    else
      acc_next = acc_sum;
  end

  // registers only
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      acc_reg <= 22'h0;
      ref_reg <= 16'h0;
    end
    else
    begin
      acc_reg <= acc_next;
      ref_reg <= ref_next;
    end
  end

  assign o_vref = ref_reg;
  assign o_busy = i_conv_en && (ref_reg != i_target);

endmodule : vml_slew_engine

//--- vml_vout_limit_margin_slew.sv
`timescale 1ns/100ps
module vml_vout_limit_margin_slew #(
  parameter logic [15:0] P_UPPER_LIMIT_RST = 16'h0b00, // stands in for the stored value
  parameter logic [15:0] P_MARGIN_HIGH_RST = 16'h0220,
  parameter logic [15:0] P_MARGIN_LOW_RST = 16'h01e0,
  parameter logic [15:0] P_NOMINAL_RST = 16'h0200,
  parameter logic [10:0] P_SLEW_MAN_RST = 11'h010 // 1 mV/us with the reset exponent
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [7:0] i_cmd_code,
  input wire logic [15:0] i_wr_data,
  input wire logic i_setpoint_wr_stb,
  input wire logic [15:0] i_strap_voltage_setpoint,
  input wire logic [15:0] i_vout_trim,
  input wire logic [15:0] i_vout_min,
  input wire logic [4:0] i_vout_exp,
  input wire logic i_vout_relative,
  input wire logic [1:0] i_loop_scale_sel,
  input wire logic [1:0] i_margin_sel,
  input wire logic i_conv_en,
  output logic [15:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_cmd_nack,
  output logic o_invalid_data,
  output logic o_limit_warning,
  output logic o_status_none_above,
  output logic o_status_word_vout,
  output logic o_notify_host,
  output logic [15:0] o_target,
  output logic [15:0] o_vref,
  output logic o_slewing
);

  initial
  begin
    if (P_NOMINAL_RST > P_UPPER_LIMIT_RST)
      $error("nominal reset value above upper limit reset value");
  end

  // ***************************************************************
  // limit conversion helpers
  // ***************************************************************
  // mV figure into output lsb counts at 2^-n V per lsb, saturating
  function automatic logic [15:0] vml_lim(input logic [12:0] mv, input logic [3:0] n);
    logic [31:0] t;
    t = ({19'h0, mv} << n) / 32'd1000;
    return (t > 32'h0000ffff) ? 16'hffff : t[15:0];
  endfunction : vml_lim

  // combined set point: base plus signed trim, held at 0..ffff
  function automatic logic [15:0] vml_sum(input logic [15:0] base, input logic [15:0] trim);
    logic signed [17:0] s;
    s = $signed({2'b00, base}) + $signed({{2{trim[15]}}, trim});
    if (s < 0)
      return 16'h0;
    return (s > 18'sh0ffff) ? 16'hffff : s[15:0];
  endfunction : vml_sum

  logic [3:0] lsb_shift; // fraction bits of the output code
  logic [4:0] exp_neg;
  logic [12:0] valid_mv;
  logic [12:0] dac_mv;
  logic [15:0] valid_lim; // valid set-point ceiling in lsb
  logic [15:0] dac_lim; // reference reach in lsb

  always_comb
  begin
    exp_neg = 5'(~i_vout_exp + 5'h1);
    if (!i_vout_exp[4])
      lsb_shift = 4'h0; // positive exponents treated as whole volts
    else if (exp_neg > 5'(vml_pkg::VML_MAX_SHIFT))
      lsb_shift = 4'(vml_pkg::VML_MAX_SHIFT); // limitation: finer codes not scaled
    else
      lsb_shift = exp_neg[3:0];
    case (i_loop_scale_sel)
      2'h0: valid_mv = vml_pkg::VML_VALID_MV_S1;
      2'h1: valid_mv = vml_pkg::VML_VALID_MV_S2;
      2'h2: valid_mv = vml_pkg::VML_VALID_MV_S4;
      default: valid_mv = vml_pkg::VML_VALID_MV_S8;
    endcase
    dac_mv = 13'(vml_pkg::VML_DAC_MV << i_loop_scale_sel);
    valid_lim = vml_lim(valid_mv, lsb_shift);
    dac_lim = vml_lim(dac_mv, lsb_shift);
  end

  // ***************************************************************
  // register file and write checks
  // ***************************************************************
  logic [15:0] upper_reg; // unsigned absolute upper limit
  logic [15:0] upper_next;
  logic [15:0] mhigh_reg;
  logic [15:0] mhigh_next;
  logic [15:0] mlow_reg;
  logic [15:0] mlow_next;
  logic [15:0] rate_reg; // slew word as written
  logic [15:0] rate_next;
  logic [7:0] eff_reg; // effective rate in 0.0625 mV/us
  logic [7:0] eff_next;
  logic [15:0] nom_reg; // nominal set point
  logic [15:0] nom_next;
  logic [15:0] rd_reg;
  logic [15:0] rd_next;
  logic rd_vld_reg;
  logic nack_reg;
  logic nack_next;
  logic inv_reg;
  logic inv_next;
  logic margin_ok;
  logic rate_ok;
  logic strap_ok;
  logic [15:0] try_sum;
  logic [15:0] margin_base;
  logic signed [4:0] r_exp;
  logic signed [5:0] r_sh;
  logic [39:0] r_q10; // decoded rate in 2^-10 mV/us
  logic [39:0] r_umv;
  logic [39:0] r_eff;

  always_comb
  begin
    // margin write: relative margins ride on the nominal set point
    margin_base = i_vout_relative ? 16'(nom_reg + i_wr_data) : i_wr_data;
    try_sum = vml_sum(margin_base, i_vout_trim);
    margin_ok = (try_sum <= valid_lim);
    strap_ok = (vml_sum(i_strap_voltage_setpoint, i_vout_trim) <= valid_lim);
    // slew word decode, negative mantissa is never valid
    r_exp = $signed(i_wr_data[vml_pkg::VML_SLEW_EXP_MSB:vml_pkg::VML_SLEW_EXP_LSB]);
    r_sh = 6'(r_exp) + 6'(vml_pkg::VML_RATE_FRAC_BITS);
    if (r_sh < 0)
      r_q10 = {29'h0, i_wr_data[vml_pkg::VML_SLEW_MAN_MSB:vml_pkg::VML_SLEW_MAN_LSB]} >> 6'(-r_sh);
    else
      r_q10 = {29'h0, i_wr_data[vml_pkg::VML_SLEW_MAN_MSB:vml_pkg::VML_SLEW_MAN_LSB]} << r_sh;
    r_umv = 40'((64'(r_q10) * 64'd1000000) >> vml_pkg::VML_RATE_FRAC_BITS);
    rate_ok = !i_wr_data[vml_pkg::VML_SLEW_MAN_MSB] && (r_exp <= 5'sd4)
      && (r_umv >= vml_pkg::VML_RATE_MIN_UMV) && (r_umv <= vml_pkg::VML_RATE_MAX_UMV);
    // nearest supported step, never zero so a move always ends
    r_eff = (r_q10 + 40'd32) >> vml_pkg::VML_EFF_SHIFT;
    if (r_eff == 40'h0)
      r_eff = 40'h1;
    else if (r_eff > 40'hff)
      r_eff = 40'hff;

    upper_next = upper_reg;
    mhigh_next = mhigh_reg;
    mlow_next = mlow_reg;
    rate_next = rate_reg;
    eff_next = eff_reg;
    nom_next = nom_reg;
    rd_next = rd_reg;
    nack_next = 1'b0;
    inv_next = 1'b0;
    if (i_setpoint_wr_stb)
    begin
      if (strap_ok)
        nom_next = i_strap_voltage_setpoint;
      else
        inv_next = 1'b1;
    end
    if (i_wr_stb)
    begin
      case (i_cmd_code)
        vml_pkg::VML_CMD_UPPER_LIMIT: upper_next = i_wr_data;
        vml_pkg::VML_CMD_MARGIN_HIGH:
        begin
          if (margin_ok)
            mhigh_next = i_wr_data;
          else
            inv_next = 1'b1;
        end
        vml_pkg::VML_CMD_MARGIN_LOW:
        begin
          if (margin_ok)
            mlow_next = i_wr_data;
          else
            inv_next = 1'b1;
        end
        vml_pkg::VML_CMD_SLEW_RATE:
        begin
          if (rate_ok)
          begin
            rate_next = i_wr_data; // stored exactly
            eff_next = r_eff[7:0];
          end
          else
            inv_next = 1'b1;
        end
        default: nack_next = 1'b1; // not served by this block
      endcase
    end
    if (i_rd_stb)
    begin
      case (i_cmd_code)
        vml_pkg::VML_CMD_UPPER_LIMIT: rd_next = upper_reg;
        vml_pkg::VML_CMD_MARGIN_HIGH: rd_next = mhigh_reg;
        vml_pkg::VML_CMD_MARGIN_LOW: rd_next = mlow_reg;
        vml_pkg::VML_CMD_SLEW_RATE: rd_next = rate_reg;
        default:
        begin
          rd_next = 16'h0;
          nack_next = 1'b1;
        end
      endcase
    end
  end

  // register stage of the register file
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      upper_reg <= P_UPPER_LIMIT_RST;
      mhigh_reg <= P_MARGIN_HIGH_RST;
      mlow_reg <= P_MARGIN_LOW_RST;
      rate_reg <= {vml_pkg::VML_SLEW_EXP_RST, P_SLEW_MAN_RST};
      eff_reg <= 8'(P_SLEW_MAN_RST);
      nom_reg <= P_NOMINAL_RST;
      rd_reg <= 16'h0;
      rd_vld_reg <= 1'b0;
      nack_reg <= 1'b0;
      inv_reg <= 1'b0;
    end
    else
    begin
      upper_reg <= upper_next;
      mhigh_reg <= mhigh_next;
      mlow_reg <= mlow_next;
      rate_reg <= rate_next;
      eff_reg <= eff_next;
      nom_reg <= nom_next;
      rd_reg <= rd_next;
      rd_vld_reg <= i_rd_stb && !nack_next;
      nack_reg <= nack_next;
      inv_reg <= inv_next;
    end
  end

  // ***************************************************************
  // target selection, clamping and warning
  // ***************************************************************
  logic [15:0] src_val; // chosen set point before trim
  logic [15:0] raw_sum; // set point plus trim
  logic [15:0] tgt_val;
  logic dac_cap;
  logic over_max;
  logic under_min;
  logic viol;
  logic [47:0] key_reg; // last checked sum and limits
  logic [47:0] key_next;
  logic warn_reg;
  logic warn_next;

  always_comb
  begin
    case (vml_pkg::vml_src_t'(i_margin_sel))
      vml_pkg::VML_SRC_HIGH:
        src_val = i_vout_relative ? 16'(nom_reg + mhigh_reg) : mhigh_reg;
      vml_pkg::VML_SRC_LOW:
        src_val = i_vout_relative ? 16'(nom_reg + mlow_reg) : mlow_reg;
      default: src_val = nom_reg;
    endcase
    raw_sum = vml_sum(src_val, i_vout_trim);
    // checks act on the final sum, after source choice and trim
    dac_cap = (raw_sum > dac_lim) && (dac_lim <= upper_reg);
    over_max = !dac_cap && (raw_sum > upper_reg);
    under_min = (raw_sum < i_vout_min);
    viol = i_conv_en && (over_max || under_min);
    if (dac_cap)
      tgt_val = dac_lim; // held by the reference reach
    else if (over_max)
      tgt_val = upper_reg;
    else if (under_min)
      tgt_val = i_vout_min;
    else
      tgt_val = raw_sum;
    // a new sum or a new limit is a target change; lowering the limit
    // under the target in force counts too
    key_next = {raw_sum, upper_reg, i_vout_min};
    warn_next = viol && (key_next != key_reg);
  end

  // register stage of the warning logic
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      key_reg <= 48'h0;
      warn_reg <= 1'b0;
    end
    else
    begin
      key_reg <= i_conv_en ? key_next : 48'h0; // rearm while off
      warn_reg <= warn_next;
    end
  end

  // ***************************************************************
  // slew engine
  // ***************************************************************
  vml_slew_engine #(
    .INC_W(20)
  ) u_slew (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_conv_en(i_conv_en),
    .i_target(tgt_val),
    .i_inc(20'({12'h0, eff_reg} << lsb_shift)),
    .o_vref(o_vref),
    .o_busy(o_slewing)
  );

  assign o_rd_data = rd_reg;
  assign o_rd_valid = rd_vld_reg;
  assign o_cmd_nack = nack_reg;
  assign o_invalid_data = inv_reg;
  assign o_limit_warning = warn_reg;
  assign o_status_none_above = warn_reg;
  assign o_status_word_vout = warn_reg;
  assign o_notify_host = warn_reg || inv_reg;
  assign o_target = tgt_val;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_limit_write_store: assert property (
    i_wr_stb && i_cmd_code == vml_pkg::VML_CMD_UPPER_LIMIT |=> upper_reg == $past(i_wr_data))
    else $error("upper limit write not stored");
  a_rate_bad_kept: assert property (
    i_wr_stb && i_cmd_code == vml_pkg::VML_CMD_SLEW_RATE && !rate_ok
    |=> o_invalid_data && $stable(rate_reg) && o_notify_host)
    else $error("bad slew word not refused");
  a_rate_readback: assert property (
    i_wr_stb && i_cmd_code == vml_pkg::VML_CMD_SLEW_RATE && rate_ok && !i_rd_stb
    ##1 !i_wr_stb && !i_rd_stb
    ##1 i_rd_stb && i_cmd_code == vml_pkg::VML_CMD_SLEW_RATE && !i_wr_stb
    |=> o_rd_data == $past(i_wr_data, 3) && o_rd_valid)
    else $error("slew word readback differs");
  a_margin_bad_kept: assert property (
    i_wr_stb && i_cmd_code == vml_pkg::VML_CMD_MARGIN_HIGH && !margin_ok
    |=> o_invalid_data && $stable(mhigh_reg))
    else $error("bad margin write not refused");
  a_clamp_upper: assert property (
    over_max |-> o_target == upper_reg && o_target < raw_sum)
    else $error("target above upper limit");
  a_clamp_lower: assert property (
    under_min && !over_max && !dac_cap |-> o_target == i_vout_min)
    else $error("target below minimum");
  a_cap_no_warn: assert property (
    dac_cap && !under_min |=> !o_limit_warning)
    else $error("warning while reference capped");
  a_warn_status: assert property (
    viol && key_next != key_reg |=> o_limit_warning && o_status_none_above
    && o_status_word_vout && o_notify_host)
    else $error("violation without status");
  a_off_follow: assert property (
    !i_conv_en ##1 !i_conv_en |-> o_vref == $past(o_target))
    else $error("reference slewed while off");
  a_no_overshoot: assert property (
    i_conv_en && $past(i_conv_en) && $stable(o_target) && $past(o_vref) <= o_target
    |-> o_vref <= o_target && o_vref - $past(o_vref) <= 16'h1)
    else $error("reference passed target");

  c_margin_warn: cover property (i_margin_sel == 2'b10 && o_limit_warning);
  c_slew_done: cover property (o_slewing ##1 !o_slewing && i_conv_en);
  c_rate_bad: cover property (i_wr_stb && i_cmd_code == vml_pkg::VML_CMD_SLEW_RATE && !rate_ok);

endmodule : vml_vout_limit_margin_slew

//--- vml_host_model.sv
`timescale 1ns/100ps
// ***************************************************************
// host side word access model
// ***************************************************************
module vml_host_model (
  input wire logic i_sys_clk,
  input wire logic i_rd_valid,
  input wire logic i_cmd_nack,
  input wire logic i_invalid_data,
  input wire logic [15:0] i_rd_data,
  output logic o_wr_stb,
  output logic o_rd_stb,
  output logic [7:0] o_cmd_code,
  output logic [15:0] o_wr_data
);
  // idle bus at time zero
  initial
  begin
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
    o_cmd_code = 8'hff;
    o_wr_data = 16'h0000;
  end
  // whole word write; the answer is taken right after the taking edge
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] data,
                            output logic inv, output logic nack);
    @(posedge i_sys_clk);
    #1;
    o_wr_stb = 1'b1;
    o_cmd_code = cmd;
    o_wr_data = data;
    @(posedge i_sys_clk);
    #1;
    inv = i_invalid_data;
    nack = i_cmd_nack;
    o_wr_stb = 1'b0;
    // released data shows the inverse, never a stale word
    o_wr_data = ~data;
  endtask : write_word
  // whole word read
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] data,
                           output logic ok);
    @(posedge i_sys_clk);
    #1;
    o_rd_stb = 1'b1;
    o_cmd_code = cmd;
    @(posedge i_sys_clk);
    #1;
    data = i_rd_data;
    ok = i_rd_valid;
    o_rd_stb = 1'b0;
  endtask : read_word
endmodule : vml_host_model

//--- tb_vml_vout_limit_margin_slew.sv
`timescale 1ns/100ps
// ***************************************************************
// bench for the output target logic
// ***************************************************************
module tb_vml_vout_limit_margin_slew;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic wr_stb, rd_stb, rd_valid, cmd_nack, inv_data, warn, st_none, st_vout, notify;
  logic [7:0] cmd;
  logic [15:0] wr_data, rd_data, target, vref;
  logic sp_stb = 1'b0;
  logic [15:0] strap = 16'h0200;
  logic [15:0] trim = 16'h0000;
  logic [15:0] vmin = 16'h0000;
  logic [4:0] vexp = 5'h17; // lsb 2^-9 V
  logic rel = 1'b0;
  logic [1:0] scale = 2'd1;
  logic [1:0] msel = 2'b10;
  logic conv = 1'b0; // off at start so vref snaps to target
  logic slewing, inv, nack, ok;
  logic [15:0] d;
  int fails = 0;
  int checks = 0;
  // ***************************************************************
  // clock, reset, watchdog
  // ***************************************************************
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    #300000;
    fails++;
    complete_run();
  end
  vml_host_model host (.i_sys_clk(sys_clk), .i_rd_valid(rd_valid), .i_cmd_nack(cmd_nack),
    .i_invalid_data(inv_data), .i_rd_data(rd_data), .o_wr_stb(wr_stb), .o_rd_stb(rd_stb),
    .o_cmd_code(cmd), .o_wr_data(wr_data));
  vml_vout_limit_margin_slew uut (.i_sys_clk(sys_clk), .i_rst(rst), .i_wr_stb(wr_stb),
    .i_rd_stb(rd_stb), .i_cmd_code(cmd), .i_wr_data(wr_data), .i_setpoint_wr_stb(sp_stb),
    .i_strap_voltage_setpoint(strap), .i_vout_trim(trim), .i_vout_min(vmin),
    .i_vout_exp(vexp), .i_vout_relative(rel), .i_loop_scale_sel(scale),
    .i_margin_sel(msel), .i_conv_en(conv), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .o_cmd_nack(cmd_nack), .o_invalid_data(inv_data), .o_limit_warning(warn),
    .o_status_none_above(st_none), .o_status_word_vout(st_vout), .o_notify_host(notify),
    .o_target(target), .o_vref(vref), .o_slewing(slewing));
  // ***************************************************************
  // shared checks
  // ***************************************************************
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // read back and compare a word
  task automatic rd_chk(input string what, input logic [7:0] c, input logic [15:0] exp);
    host.read_word(c, d, ok);
    check({what, " valid"}, 16'h1, {15'h0, ok});
    check(what, exp, d);
  endtask : rd_chk
  // look a few cycles for a warning pulse; status pulses ride with it
  task automatic warn_chk(input string what, input logic exp);
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < 4; n++)
    begin
      @(posedge sys_clk);
      #1;
      if (warn === 1'b1)
      begin
        seen = 1'b1;
        check("status byte", 16'h1, {15'h0, st_none});
        check("status word", 16'h1, {15'h0, st_vout});
        check("notify", 16'h1, {15'h0, notify});
      end
    end
    check(what, {15'h0, exp}, {15'h0, seen});
  endtask : warn_chk
  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_reset_values;
    rd_chk("upper rst", 8'h24, 16'h0b00);
    rd_chk("mhigh rst", 8'h25, 16'h0220);
    rd_chk("mlow rst", 8'h26, 16'h01e0);
    rd_chk("slew rst", 8'h27, 16'he010);
    host.write_word(8'h28, 16'h1234, inv, nack);
    check("nack wr", 16'h1, {15'h0, nack});
    host.read_word(8'h23, d, ok);
    check("nack rd", 16'h1, {15'h0, cmd_nack});
  endtask : t_reset_values
  // last valid write stands; out-of-range words are refused
  task automatic t_slew_word;
    logic [15:0] bad [3] = '{16'he7ff, 16'he001, 16'he0ff};
    host.write_word(8'h27, 16'he801, inv, nack);
    rd_chk("slew exp -3", 8'h27, 16'he801);
    host.write_word(8'h27, 16'he0fe, inv, nack);
    check("slew ok", 16'h0, {15'h0, inv});
    foreach (bad[i])
    begin
      host.write_word(8'h27, bad[i], inv, nack);
      check("slew refused", 16'h1, {15'h0, inv});
    end
    rd_chk("slew kept", 8'h27, 16'he0fe);
  endtask : t_slew_word
  // ceiling per loop scale, one code above it refused
  task automatic t_validity;
    int mv [4] = '{700, 1400, 2800, 6000};
    logic [15:0] lim;
    msel = 2'b00;
    for (int s = 0; s < 4; s++)
    begin
      scale = 2'(s);
      lim = 16'(mv[s] * 512 / 1000);
      host.write_word(8'h26, lim, inv, nack);
      check("ceiling ok", 16'h0, {15'h0, inv});
      host.write_word(8'h26, lim + 16'h1, inv, nack);
      check("ceiling over", 16'h1, {15'h0, inv});
      rd_chk("ceiling kept", 8'h26, lim);
    end
    scale = 2'd1;
    host.write_word(8'h25, 16'h02cd, inv, nack);
    check("mhigh over", 16'h1, {15'h0, inv});
    host.write_word(8'h26, 16'h01e0, inv, nack);
  endtask : t_validity
  task automatic t_margin_target;
    msel = 2'b10;
    #20;
    check("mhigh tgt", 16'h0220, target);
    trim = 16'h0005;
    #20;
    check("trim up", 16'h0225, target);
    msel = 2'b01;
    trim = 16'hfffb;
    #20;
    check("trim down", 16'h01db, target);
    rel = 1'b1;
    host.write_word(8'h26, 16'h0010, inv, nack);
    #20;
    check("relative", 16'h020b, target);
    rel = 1'b0;
    trim = 16'h0000;
    host.write_word(8'h26, 16'h01e0, inv, nack);
    // both margin bits set falls back to the nominal set point
    msel = 2'b11;
    #20;
    check("msel both", 16'h0200, target);
  endtask : t_margin_target
  task automatic t_limits;
    msel = 2'b10;
    host.write_word(8'h24, 16'h0210, inv, nack);
    warn_chk("upper warn", 1'b1);
    check("upper clamp", 16'h0210, target);
    host.write_word(8'h24, 16'hffff, inv, nack);
    msel = 2'b01;
    vmin = 16'h0250;
    warn_chk("lower warn", 1'b1);
    check("lower clamp", 16'h0250, target);
    vmin = 16'h0000;
    msel = 2'b10;
    trim = 16'h0100;
    warn_chk("dac cap quiet", 1'b0);
    check("dac cap", 16'h0300, target);
    trim = 16'h0000;
  endtask : t_limits
  // stepped approach at the set rate, no overshoot; off snaps at once
  task automatic t_slew_motion;
    int n;
    conv = 1'b0;
    msel = 2'b00;
    repeat (2) @(posedge sys_clk);
    #1;
    check("off snap", 16'h0200, vref);
    conv = 1'b1;
    msel = 2'b10;
    for (n = 0; n < 2000 && vref !== 16'h0220; n++)
    begin
      @(posedge sys_clk);
      #1;
      if (n == 0)
        check("slew busy", 16'h1, {15'h0, slewing});
      if (vref > 16'h0220)
        check("overshoot", 16'h0220, vref);
    end
    check("slew end", 16'h0220, vref);
    check("slew idle", 16'h0, {15'h0, slewing});
    // 32 lsb of 2^-9 V at 15.875 mV/us take about 394 cycles
    check("slew paced", 16'h1, {15'h0, n > 380 && n < 410});
  endtask : t_slew_motion
  // strap set point load: over-ceiling refused, valid taken
  task automatic t_setpoint;
    msel = 2'b00;
    strap = 16'h02cd;
    @(posedge sys_clk);
    #1;
    sp_stb = 1'b1;
    @(posedge sys_clk);
    #1;
    check("strap refused", 16'h1, {15'h0, inv_data});
    check("strap notify", 16'h1, {15'h0, notify});
    // refused load leaves the nominal set point as it was
    check("strap kept", 16'h0200, target);
    strap = 16'h0210;
    @(posedge sys_clk);
    #1;
    check("strap ok", 16'h0, {15'h0, inv_data});
    sp_stb = 1'b0;
    #20;
    check("strap tgt", 16'h0210, target);
  endtask : t_setpoint
  // ***************************************************************
  // verdict and main sequence
  // ***************************************************************
  task automatic complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (3) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    t_reset_values();
    t_slew_word();
    t_validity();
    conv = 1'b1;
    t_margin_target();
    t_limits();
    t_slew_motion();
    t_setpoint();
    complete_run();
  end
endmodule : tb_vml_vout_limit_margin_slew
